/* hw/dsr_pkg.sv */
package dsr_pkg;

  // Command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_DES     = 4'hF;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_ZQCL    = 4'h6;

  // Mode register 2 field positions
  localparam int MR2_ARR_BIT = 6;
  localparam int MR2_SRR_BIT = 7;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Interval figures in clock cycles of the link clock
  localparam int T_CKESR_CYC   = 5;
  localparam int T_CKE_CYC     = 3;
  localparam int T_XS_CYC      = 28;
  localparam int T_XSDLL_CYC   = 512;
  localparam int T_ZQOPER_CYC  = 256;
  localparam int T_VREF_WR_CYC = 512;
  localparam int T_DLL_RST_CYC = 16;

  // Temperature thresholds, degrees C
  localparam int TEMP_NORMAL_MAX = 85;
  localparam int TEMP_EXT_MAX    = 95;

  // Refresh rate selection reported by the device
  localparam logic [1:0] RATE_NORMAL = 2'h0;
  localparam logic [1:0] RATE_EXT    = 2'h1;
  localparam logic [1:0] RATE_AUTO   = 2'h2;

  typedef enum logic [2:0] {
    DSR_IDLE  = 3'h1,
    DSR_SELF  = 3'h2,
    DSR_EXIT  = 3'h4
  } dsr_dev_state_t;

  typedef enum logic [4:0] {
    DSH_RUN   = 5'h01,
    DSH_ENTRY = 5'h02,
    DSH_HOLD  = 5'h04,
    DSH_XS    = 5'h08,
    DSH_XSDLL = 5'h10
  } dsr_host_state_t;

endpackage

/* hw/dsr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsr_link_if;
  logic       cke;
  logic [3:0] cmd;
  logic       odt;
  logic       reset_n;
  logic       mr2_arr;
  logic       mr2_srr;

  modport ctrl (
    output cke,
    output cmd,
    output odt,
    output reset_n,
    output mr2_arr,
    output mr2_srr
  );
  modport dram (
    input cke,
    input cmd,
    input odt,
    input reset_n,
    input mr2_arr,
    input mr2_srr
  );
endinterface
`default_nettype wire

/* hw/dsr_dram.sv */
// Overview of operation
// - Refresh with CKE low enters self refresh
// - DLL off in self refresh, reset on exit
// - First write 512 clocks after reference valid
// - All banks idle before entry
// - ODT low before entry unless termination off
// - CKE held low during self refresh
// - Only CKE and reset matter inside; here the MR2 bits still set the rate and high power outputs
// - One internal refresh within tCKE
// - Exit allowed after tCKESR, stable clock
// - Clock change needs tCKSRE and tCKSRX
// - Only NOP or deselect during tXS
// - No re-entry before tXS
// - ZQ long calibration before DLL commands
// - ODT off throughout tXSDLL
// - NOP after entry and before exit
// - Exit on CKE rise, intervals counted then
// - Double refresh rate above 85C
// - Hot self refresh needs automatic or extended
// - Range bit picks normal or extended
// - Automatic bit lets device choose rate
// - Both bits set is illegal
// - Extended range costs more power
`timescale 1ns/1ps
`default_nettype none
module dsr_dram (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Link
  dsr_link_if.dram        link,
  // Status
  output logic            self_refresh_out,
  output logic            dll_enabled_out,
  output logic            dll_reset_out,
  output logic            int_refresh_out,
  output logic [1:0]      refresh_rate_out,
  output logic            high_power_out,
  output logic            mode_illegal_out,
  output logic            xs_done_out
);

  dsr_pkg::dsr_dev_state_t state;
  logic        cke_q;
  logic [9:0]  dll_cnt;
  logic [9:0]  xs_cnt;
  logic [3:0]  ref_cnt;
  logic        ref_done;
  logic        sr_entry;

  // Link comes from flops on this clock; a synchroniser on CKE alone
  // would slip it behind the command it qualifies
  // Last CKE, so only a fresh fall with REFRESH enters
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= link.cke;
    end
  end

  assign sr_entry = (state == dsr_pkg::DSR_IDLE) && !link.cke && cke_q &&
                    (link.cmd == dsr_pkg::CMD_REFRESH);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= dsr_pkg::DSR_IDLE;
    end else if (!link.reset_n) begin
      // Link reset drops the device to idle whatever it was doing
      state <= dsr_pkg::DSR_IDLE;
    end else begin
      case (state)
        dsr_pkg::DSR_IDLE: begin
          if (sr_entry) begin
            state <= dsr_pkg::DSR_SELF;
          end
        end
        dsr_pkg::DSR_SELF: begin
          if (link.cke) begin
            state <= dsr_pkg::DSR_EXIT;
          end
        end
        dsr_pkg::DSR_EXIT: begin
          if (xs_cnt == 10'(dsr_pkg::T_XS_CYC - 1)) begin
            state <= dsr_pkg::DSR_IDLE;
          end
        end
        default: state <= dsr_pkg::DSR_IDLE;
      endcase
    end
  end

  // tXS counted from first high sample
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xs_cnt <= 10'h000;
    end else if (state == dsr_pkg::DSR_EXIT) begin
      xs_cnt <= xs_cnt + 10'h001;
    end else begin
      xs_cnt <= 10'h000;
    end
  end

  // One pulse per entry; later refreshes stay internal
  // internal refresh soon after entry
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_cnt         <= 4'h0;
      ref_done        <= 1'b0;
      int_refresh_out <= 1'b0;
    end else begin
      int_refresh_out <= 1'b0;
      if (state != dsr_pkg::DSR_SELF) begin
        ref_cnt  <= 4'h0;
        ref_done <= 1'b0;
      end else if (!ref_done) begin
        ref_cnt <= ref_cnt + 4'h1;
        if (ref_cnt == 4'(dsr_pkg::T_CKE_CYC - 2)) begin
          int_refresh_out <= 1'b1;
          ref_done        <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dll_enabled_out <= 1'b1;
    end else begin
      dll_enabled_out <= (state != dsr_pkg::DSR_SELF);
    end
  end

  // reset pulse as the DLL returns
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dll_reset_out <= 1'b0;
      dll_cnt       <= 10'h000;
    end else if (state == dsr_pkg::DSR_SELF) begin
      dll_reset_out <= 1'b0;
      dll_cnt       <= 10'h000;
    end else if (!dll_enabled_out) begin
      dll_reset_out <= 1'b1;
    end else if (dll_reset_out) begin
      dll_cnt <= dll_cnt + 10'h001;
      if (dll_cnt == 10'(dsr_pkg::T_DLL_RST_CYC - 1)) begin
        dll_reset_out <= 1'b0;
      end
    end
  end

  // Mode bits read live; the host drives them from its enables every cycle, in self refresh too
  // automatic bit overrides range bit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      refresh_rate_out <= dsr_pkg::RATE_NORMAL;
    end else if (link.mr2_arr) begin
      refresh_rate_out <= dsr_pkg::RATE_AUTO;
    end else if (link.mr2_srr) begin
      refresh_rate_out <= dsr_pkg::RATE_EXT;
    end else begin
      refresh_rate_out <= dsr_pkg::RATE_NORMAL;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      high_power_out <= 1'b0;
    end else begin
      high_power_out <= !link.mr2_arr && link.mr2_srr && (state == dsr_pkg::DSR_SELF);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_illegal_out <= 1'b0;
    end else begin
      mode_illegal_out <= link.mr2_arr && link.mr2_srr;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      self_refresh_out <= 1'b0;
    end else begin
      self_refresh_out <= (state == dsr_pkg::DSR_SELF);
    end
  end

  // idle again once tXS has run
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xs_done_out <= 1'b1;
    end else begin
      xs_done_out <= (state == dsr_pkg::DSR_IDLE);
    end
  end

endmodule // dsr_dram
`default_nettype wire

/* hw/dsr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_ctrl (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // User requests
  input  wire logic       sr_req_in,
  input  wire logic       sr_exit_in,
  input  wire logic       banks_idle_in,
  input  wire logic       temp_hot_in,
  input  wire logic       arr_en_in,
  input  wire logic       srr_en_in,
  input  wire logic       odt_req_in,
  input  wire logic [3:0] cmd_in,
  // Link
  dsr_link_if.ctrl        link,
  // Status
  output logic            in_sr_out,
  output logic            dll_cmd_ok_out,
  output logic            cmd_ok_out,
  output logic            double_rate_out
);

  dsr_pkg::dsr_host_state_t state;
  logic [9:0] cnt;
  logic [9:0] zq_cnt;
  logic       zq_done;
  logic       can_enter;

  // banks idle; hot needs a mode
  assign can_enter = sr_req_in && banks_idle_in &&
                     (!temp_hot_in || arr_en_in || srr_en_in);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= dsr_pkg::DSH_RUN;
      cnt   <= 10'h000;
    end else begin
      case (state)
        dsr_pkg::DSH_RUN: begin
          if (can_enter) begin
            state <= dsr_pkg::DSH_ENTRY;
          end
        end
        dsr_pkg::DSH_ENTRY: begin
          state <= dsr_pkg::DSH_HOLD;
          cnt   <= 10'h000;
        end
        dsr_pkg::DSH_HOLD: begin
          if (cnt < 10'(dsr_pkg::T_CKESR_CYC)) begin
            cnt <= cnt + 10'h001;
          end else if (sr_exit_in) begin
            state <= dsr_pkg::DSH_XS;
            cnt   <= 10'h000;
          end
        end
        dsr_pkg::DSH_XS: begin
          cnt <= cnt + 10'h001;
          if (cnt == 10'(dsr_pkg::T_XS_CYC - 1)) begin
            state <= dsr_pkg::DSH_XSDLL;
          end
        end
        dsr_pkg::DSH_XSDLL: begin
          if (cnt >= 10'(dsr_pkg::T_XSDLL_CYC - 1) && zq_done) begin
            state <= dsr_pkg::DSH_RUN;
          end else if (cnt < 10'(dsr_pkg::T_XSDLL_CYC - 1)) begin
            cnt <= cnt + 10'h001;
          end
        end
        default: state <= dsr_pkg::DSH_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      zq_cnt  <= 10'h000;
      zq_done <= 1'b0;
    end else if (state != dsr_pkg::DSH_XSDLL) begin
      zq_cnt  <= 10'h000;
      zq_done <= 1'b0;
    end else if (!zq_done) begin
      zq_cnt <= zq_cnt + 10'h001;
      zq_done <= (zq_cnt == 10'(dsr_pkg::T_ZQOPER_CYC));
    end
  end

  // Link drive; entry, NOPs, ODT
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.cke     <= 1'b0;
      link.cmd     <= dsr_pkg::CMD_NOP;
      link.odt     <= 1'b0;
      link.reset_n <= 1'b0;
      link.mr2_arr <= 1'b0;
      link.mr2_srr <= 1'b0;
    end else begin
      link.reset_n <= 1'b1;
      link.mr2_arr <= arr_en_in;
      link.mr2_srr <= srr_en_in && !arr_en_in;
      link.odt     <= odt_req_in && (state == dsr_pkg::DSH_RUN) && !can_enter;
      link.cke     <= !(state == dsr_pkg::DSH_ENTRY || state == dsr_pkg::DSH_HOLD);
      if (state == dsr_pkg::DSH_ENTRY) begin
        link.cmd <= dsr_pkg::CMD_REFRESH;
      end else if (state == dsr_pkg::DSH_XSDLL && zq_cnt == 10'h000) begin
        link.cmd <= dsr_pkg::CMD_ZQCL;
      end else if (state == dsr_pkg::DSH_RUN && !can_enter) begin
        link.cmd <= cmd_in;
      end else begin
        link.cmd <= dsr_pkg::CMD_NOP;
      end
    end
  end

  // double refresh when hot via double_rate_out; DLL commands via dll_cmd_ok
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_sr_out       <= 1'b0;
      dll_cmd_ok_out  <= 1'b0;
      cmd_ok_out      <= 1'b0;
      double_rate_out <= 1'b0;
    end else begin
      in_sr_out       <= (state == dsr_pkg::DSH_HOLD);
      dll_cmd_ok_out  <= (state == dsr_pkg::DSH_RUN);
      cmd_ok_out      <= (state == dsr_pkg::DSH_RUN) || (state == dsr_pkg::DSH_XSDLL);
      double_rate_out <= temp_hot_in;
    end
  end

endmodule // dsr_ctrl
`default_nettype wire

/* dv/dsr_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_link_properties (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rstn_in,
  // Link
  input wire logic       cke,
  input wire logic [3:0] cmd,
  input wire logic       odt,
  input wire logic       mr2_arr,
  input wire logic       mr2_srr
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic       entry;
  logic       idle_cmd;
  logic       exit_now;
  logic       in_sr;
  logic       zq_seen;
  logic [4:0] xs_cnt;
  logic [8:0] dll_cnt;

  assign entry    = !cke && cmd == dsr_pkg::CMD_REFRESH;
  assign idle_cmd = cmd == dsr_pkg::CMD_NOP || cmd == dsr_pkg::CMD_DES;
  // Only a rise after an entry counts, not the power-up rise
  assign exit_now = cke && in_sr;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_sr <= 1'b0;
    end else if (entry) begin
      in_sr <= 1'b1;
    end else if (cke) begin
      in_sr <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xs_cnt <= 5'h00;
    end else if (exit_now) begin
      xs_cnt <= 5'(dsr_pkg::T_XS_CYC - 1);
    end else if (xs_cnt != 5'h00) begin
      xs_cnt <= xs_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dll_cnt <= 9'h000;
    end else if (exit_now) begin
      dll_cnt <= 9'(dsr_pkg::T_XSDLL_CYC - 1);
    end else if (dll_cnt != 9'h000) begin
      dll_cnt <= dll_cnt - 9'h001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      zq_seen <= 1'b1;
    end else if (exit_now) begin
      zq_seen <= 1'b0;
    end else if (cmd == dsr_pkg::CMD_ZQCL) begin
      zq_seen <= 1'b1;
    end
  end

  entry_code_a: assert property (
    $fell(cke) |-> cmd == dsr_pkg::CMD_REFRESH) else $error("cke fell without refresh");
  entry_nop_a: assert property (
    entry |=> idle_cmd) else $error("no nop after entry");
  entry_odt_a: assert property (
    entry |-> !odt) else $error("odt high at entry");
  cke_hold_a: assert property (
    $fell(cke) |-> !cke [*5]) else $error("cke rose before ckesr");
  exit_nop_a: assert property (
    (exit_now || xs_cnt != 5'h00) |-> idle_cmd) else $error("command inside xs");
  reentry_gap_a: assert property (
    entry |-> xs_cnt == 5'h00 && $past(cke)) else $error("early reentry");
  xsdll_odt_a: assert property (
    (exit_now || dll_cnt != 9'h000) |-> !odt) else $error("odt high inside xsdll");
  dll_cmd_a: assert property (
    (cmd == dsr_pkg::CMD_READ || cmd == dsr_pkg::CMD_WRITE) |-> zq_seen && dll_cnt == 9'h000)
    else $error("dll command too early");
  mode_legal_a: assert property (
    mr2_arr |-> !mr2_srr) else $error("both mode bits set");
endmodule // dsr_link_properties
`default_nettype wire

/* dv/dsr_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_tb_top;
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       sr_req = 1'b0;
  logic       sr_exit = 1'b0;
  logic       banks_idle = 1'b1;
  logic       temp_hot = 1'b0;
  logic       arr_en = 1'b0;
  logic       srr_en = 1'b0;
  logic       odt_req = 1'b0;
  logic [3:0] cmd_in = dsr_pkg::CMD_NOP;
  logic       in_sr, dll_ok, cmd_ok, dbl;
  logic       sr, dll_en, dll_rst, iref, hi_pwr, illegal, xs_done;
  logic [1:0] rate;
  int         n_mismatch = 0;
  int         total_checks = 0;

  always #5 clk_in = ~clk_in;

  dsr_link_if dsr_link_if_i ();
  dsr_ctrl dsr_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in), .sr_req_in(sr_req),
    .sr_exit_in(sr_exit), .banks_idle_in(banks_idle), .temp_hot_in(temp_hot),
    .arr_en_in(arr_en), .srr_en_in(srr_en), .odt_req_in(odt_req), .cmd_in(cmd_in),
    .link(dsr_link_if_i), .in_sr_out(in_sr), .dll_cmd_ok_out(dll_ok),
    .cmd_ok_out(cmd_ok), .double_rate_out(dbl));
  dsr_dram dsr_dram_i (.clk_in(clk_in), .rstn_in(rstn_in), .link(dsr_link_if_i),
    .self_refresh_out(sr), .dll_enabled_out(dll_en), .dll_reset_out(dll_rst),
    .int_refresh_out(iref), .refresh_rate_out(rate), .high_power_out(hi_pwr),
    .mode_illegal_out(illegal), .xs_done_out(xs_done));
  dsr_link_properties dsr_link_properties_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .cke(dsr_link_if_i.cke), .cmd(dsr_link_if_i.cmd), .odt(dsr_link_if_i.odt),
    .mr2_arr(dsr_link_if_i.mr2_arr), .mr2_srr(dsr_link_if_i.mr2_srr));

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_val(input string nm, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_refuse();
    banks_idle = 1'b0;
    sr_req = 1'b1;
    repeat (20) @(negedge clk_in);
    chk_bit("busy_entry", 1'b0, in_sr);
    banks_idle = 1'b1;
    temp_hot = 1'b1;
    repeat (20) @(negedge clk_in);
    chk_bit("hot_entry", 1'b0, in_sr);
    chk_bit("double_rate", 1'b1, dbl);
    sr_req = 1'b0;
    temp_hot = 1'b0;
    repeat (4) @(negedge clk_in);
    chk_bit("normal_rate", 1'b0, dbl);
  endtask

  task automatic t_modes();
    logic [1:0] m;
    logic [1:0] want;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      arr_en = m[1];
      srr_en = m[0];
      repeat (6) @(negedge clk_in);
      want = m[1] ? dsr_pkg::RATE_AUTO : (m[0] ? dsr_pkg::RATE_EXT : dsr_pkg::RATE_NORMAL);
      chk_bit("illegal", 1'b0, illegal);
      chk_bit("arr_bit", m[1], dsr_link_if_i.mr2_arr);
      chk_bit("srr_bit", m[0] && !m[1], dsr_link_if_i.mr2_srr);
      chk_val("rate", {2'h0, want}, {2'h0, rate});
      chk_bit("high_power", 1'b0, hi_pwr);
    end
    arr_en = 1'b0;
    srr_en = 1'b0;
  endtask

  // Hot run also asks for exit at once, so the ckesr wait is exercised
  task automatic t_sr(input logic hot);
    int   n;
    logic seen;
    temp_hot = hot;
    arr_en = hot;
    srr_en = !hot;
    odt_req = 1'b1;
    repeat (6) @(negedge clk_in);
    sr_req = 1'b1;
    for (n = 0; n < 20 && in_sr !== 1'b1; n++) @(negedge clk_in);
    sr_req = 1'b0;
    chk_bit("in_sr", 1'b1, in_sr);
    chk_bit("cke_low", 1'b0, dsr_link_if_i.cke);
    seen = 1'b0;
    for (n = 0; n < 8 && !hot; n++) begin
      @(negedge clk_in);
      seen = seen | (iref === 1'b1);
    end
    if (!hot) begin
      chk_bit("self_refresh", 1'b1, sr);
      chk_bit("int_refresh", 1'b1, seen);
      chk_bit("dll_off", 1'b0, dll_en);
      chk_bit("sr_high_power", 1'b1, hi_pwr);
      chk_val("sr_rate", {2'h0, dsr_pkg::RATE_EXT}, {2'h0, rate});
    end
    sr_exit = 1'b1;
    for (n = 0; n < 40 && dsr_link_if_i.cke !== 1'b1; n++) @(negedge clk_in);
    sr_exit = 1'b0;
    if (hot) chk_bit("ckesr_wait", 1'b1, n >= dsr_pkg::T_CKESR_CYC);
    seen = 1'b0;
    for (n = 0; n < 700 && dll_ok !== 1'b1; n++) begin
      @(negedge clk_in);
      seen = seen | (dll_rst === 1'b1);
    end
    chk_bit("xsdll_wait", 1'b1, n >= dsr_pkg::T_XSDLL_CYC - 2);
    chk_bit("dll_cmd_ok", 1'b1, dll_ok);
    chk_bit("dll_reset", 1'b1, seen);
    chk_bit("dll_on", 1'b1, dll_en);
    chk_bit("sr_left", 1'b0, sr);
    chk_bit("xs_done", 1'b1, xs_done);
    chk_bit("cmd_ok", 1'b1, cmd_ok);
    cmd_in = dsr_pkg::CMD_WRITE;
    repeat (3) @(negedge clk_in);
    chk_val("cmd_pass", dsr_pkg::CMD_WRITE, dsr_link_if_i.cmd);
    cmd_in = dsr_pkg::CMD_NOP;
    odt_req = 1'b0;
    temp_hot = 1'b0;
    arr_en = 1'b0;
    srr_en = 1'b0;
  endtask

  initial begin
    repeat (12) @(negedge clk_in);
    rstn_in = 1'b1;
    for (int i = 0; i < 200 && dsr_link_if_i.cke !== 1'b1; i++) @(negedge clk_in);
    t_refuse();
    t_modes();
    t_sr(1'b0);
    t_sr(1'b1);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    give_verdict();
  end
endmodule // dsr_tb_top
`default_nettype wire
